// >>> rtl/tmoc_pkg.sv
// Constants, types and register map of the compare channel output block.
// Assumes a single timer clock and an AXI4-Lite master on the same clock.
//
// Overview of operation
// [R01] Trigger forces reference active when enabled
// [R02] Forcing ends at next overflow or underflow
// [R03] Forcing only in PWM mode 1 or 2
// [R04] Preload off: new compare used at once
// [R05] Preload on: compare copied on update event
// [R06] Mode field sits at bits 8 and 2:0
// [R07] Hold, low, high or toggle on match
// [R08] Force inactive or force active modes
// [R09] PWM mode 1 levels against compare value
// [R10] PWM mode 2 levels against compare value
// [R11] Asymmetric mode 1 uses alternate when down
// [R12] Asymmetric mode 2 uses alternate when down
// [R13] Software sets center-aligned counting for asymmetric modes
package tmoc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CONFIG = 12'h048;
  localparam logic [11:0] OFF_COMPARE = 12'h060;
  localparam logic [11:0] OFF_ALTERNATE = 12'h064;
  localparam logic [11:0] OFF_STATUS = 12'h068;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_MODE_HI = 8;
  localparam int CFG_IMAE = 5;
  localparam int CFG_PRE = 4;
  localparam int STAT_REF = 0;
  localparam int STAT_FORCE = 1;
  localparam logic [31:0] CFG_WMASK = 32'h0000_0137;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] COMPARE_RESET = 32'h0000_0000;
  localparam logic [31:0] ALTERNATE_RESET = 32'h0000_0000;
  localparam logic REF_RESET = 1'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Output modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_HOLD = 4'b0000,
    MODE_MATCH_LOW = 4'b0001,
    MODE_MATCH_HIGH = 4'b0010,
    MODE_MATCH_TOGGLE = 4'b0011,
    MODE_FORCE_LOW = 4'b0100,
    MODE_FORCE_HIGH = 4'b0101,
    MODE_PWM1 = 4'b0110,
    MODE_PWM2 = 4'b0111,
    MODE_ASYM1 = 4'b1110,
    MODE_ASYM2 = 4'b1111
  } tmoc_mode_e;

  // Timer events from the counter on the same clock
  typedef struct packed {
    logic down;
    logic update;
    logic wrap;
    logic trigger;
  } tmoc_timer_s;

endpackage

// >>> rtl/tmoc_ref_gen.sv
// Next level of the output reference from mode and counter comparison.
// Assumes counter and compare values share the same width and clock.
module tmoc_ref_gen #(
  parameter int CNT_W = 16
) (
  // Configuration
  input wire tmoc_pkg::tmoc_mode_e mode,
  input wire logic force_active,
  // Comparison operands
  input wire logic [CNT_W-1:0] cnt,
  input wire logic [CNT_W-1:0] ccr,
  input wire logic [CNT_W-1:0] acr,
  input wire logic down,
  // Reference level
  input wire logic ref_now,
  output logic ref_nxt
);

  // ----------------------------------------------------------------
  // Comparisons
  // ----------------------------------------------------------------
  wire logic match = (cnt == ccr);
  wire logic below = (cnt < ccr);
  wire logic above = (cnt > ccr);
  wire logic above_alt = (cnt > acr);
  wire logic pwm1_lvl = down ? !above : below;
  wire logic pwm2_lvl = down ? above : !below;

  // Mode selection, then forcing on top
  always_comb
  begin
    ref_nxt = ref_now;
    case (mode)
      tmoc_pkg::MODE_HOLD: ref_nxt = ref_now;
      tmoc_pkg::MODE_MATCH_LOW: ref_nxt = match ? 1'h0 : ref_now; // see [R07]
      tmoc_pkg::MODE_MATCH_HIGH: ref_nxt = match ? 1'h1 : ref_now; // see [R07]
      tmoc_pkg::MODE_MATCH_TOGGLE: ref_nxt = match ? !ref_now : ref_now; // see [R07]
      tmoc_pkg::MODE_FORCE_LOW: ref_nxt = 1'h0; // see [R08]
      tmoc_pkg::MODE_FORCE_HIGH: ref_nxt = 1'h1; // see [R08]
      tmoc_pkg::MODE_PWM1: ref_nxt = pwm1_lvl; // see [R09]
      tmoc_pkg::MODE_PWM2: ref_nxt = pwm2_lvl; // see [R10]
      tmoc_pkg::MODE_ASYM1: ref_nxt = down ? !above_alt : below; // see [R11]
      tmoc_pkg::MODE_ASYM2: ref_nxt = down ? above_alt : !below; // see [R12]
      default: ref_nxt = ref_now;
    endcase
    if (force_active)
    begin
      ref_nxt = 1'h1; // see [R01]
    end
  end

endmodule

// >>> rtl/tmoc_channel.sv
// Compare channel output stage with AXI4-Lite register access.
// Assumes counter value and events come from logic on the same clock.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module tmoc_channel #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [tmoc_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [tmoc_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Timer side
  input wire logic [CNT_W-1:0] counter_value,
  input wire tmoc_pkg::tmoc_timer_s timer_events,
  output logic output_reference
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (CNT_W < 1 || CNT_W > 32)
  begin : g_bad_width
    $error("CNT_W must lie between 1 and 32");
  end

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_hold_r, w_hold_r;
  logic [tmoc_pkg::ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] cfg_r;
  logic [CNT_W-1:0] ccr_buf_r, ccr_act_r, acr_r;
  logic force_r;
  logic ref_r;
  logic ref_nxt;

  // ----------------------------------------------------------------
  // Write channel decode
  // ----------------------------------------------------------------
  wire logic aw_take = awvalid && awready_r;
  wire logic w_take = wvalid && wready_r;
  wire logic wr_do = aw_hold_r && w_hold_r && !bvalid_r;
  wire logic aw_hold_nxt = (aw_hold_r || aw_take) && !wr_do;
  wire logic w_hold_nxt = (w_hold_r || w_take) && !wr_do;
  wire logic bvalid_nxt = wr_do || (bvalid_r && !bready);
  wire logic wr_cfg = wr_do && (awaddr_r == tmoc_pkg::OFF_CONFIG);
  wire logic wr_ccr = wr_do && (awaddr_r == tmoc_pkg::OFF_COMPARE);
  wire logic wr_acr = wr_do && (awaddr_r == tmoc_pkg::OFF_ALTERNATE);
  wire logic wr_stat = wr_do && (awaddr_r == tmoc_pkg::OFF_STATUS);
  wire logic wr_hit = wr_cfg || wr_ccr || wr_acr || wr_stat;
  wire logic [31:0] cfg_merged = merge(cfg_r, wdata_r, wstrb_r) & tmoc_pkg::CFG_WMASK;
  wire logic [31:0] ccr_merged = merge(32'(ccr_buf_r), wdata_r, wstrb_r);
  wire logic [31:0] acr_merged = merge(32'(acr_r), wdata_r, wstrb_r);

  // ----------------------------------------------------------------
  // Read channel decode
  // ----------------------------------------------------------------
  wire logic ar_take = arvalid && arready_r;
  wire logic rvalid_nxt = ar_take || (rvalid_r && !rready);
  wire logic rd_cfg = (araddr == tmoc_pkg::OFF_CONFIG);
  wire logic rd_ccr = (araddr == tmoc_pkg::OFF_COMPARE);
  wire logic rd_acr = (araddr == tmoc_pkg::OFF_ALTERNATE);
  wire logic rd_stat = (araddr == tmoc_pkg::OFF_STATUS);
  wire logic rd_hit = rd_cfg || rd_ccr || rd_acr || rd_stat;
  wire logic [31:0] stat_word = (32'(force_r) << tmoc_pkg::STAT_FORCE)
                                | (32'(ref_r) << tmoc_pkg::STAT_REF);
  wire logic [31:0] rd_word = rd_cfg ? cfg_r :
                              rd_ccr ? 32'(ccr_buf_r) :
                              rd_acr ? 32'(acr_r) :
                              rd_stat ? stat_word : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  wire tmoc_pkg::tmoc_mode_e mode_sel =
    tmoc_pkg::tmoc_mode_e'({cfg_r[tmoc_pkg::CFG_MODE_HI], cfg_r[2:0]}); // see [R06]
  wire logic preload_en = cfg_r[tmoc_pkg::CFG_PRE];
  wire logic imae_en = cfg_r[tmoc_pkg::CFG_IMAE];
  wire logic pwm12 = (mode_sel == tmoc_pkg::MODE_PWM1) || (mode_sel == tmoc_pkg::MODE_PWM2);
  wire logic imae_arm = imae_en && pwm12; // see [R03]
  wire logic force_set = imae_arm && timer_events.trigger; // see [R01]
  wire logic force_nxt = force_set || (force_r && !timer_events.wrap); // see [R02]
  wire logic force_now = imae_arm && (force_r || timer_events.trigger); // see [R03]

  // Write channel handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'h0;
      w_hold_r <= 1'h0;
      awready_r <= 1'h0;
      wready_r <= 1'h0;
      bvalid_r <= 1'h0;
      bresp_r <= tmoc_pkg::RESP_OKAY;
    end
    else
    begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awready_r <= !aw_hold_nxt;
      wready_r <= !w_hold_nxt;
      bvalid_r <= bvalid_nxt;
      if (wr_do)
      begin
        bresp_r <= wr_hit ? tmoc_pkg::RESP_OKAY : tmoc_pkg::RESP_SLVERR;
      end
    end
  end

  // Captured write address and data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        awaddr_r <= awaddr;
      end
      if (w_take)
      begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
    end
  end

  // Read channel handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'h0;
      rvalid_r <= 1'h0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= tmoc_pkg::RESP_OKAY;
    end
    else
    begin
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take)
      begin
        rdata_r <= rd_word;
        rresp_r <= rd_hit ? tmoc_pkg::RESP_OKAY : tmoc_pkg::RESP_SLVERR;
      end
    end
  end

  // Configuration and alternate compare storage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_r <= tmoc_pkg::CONFIG_RESET;
      acr_r <= tmoc_pkg::ALTERNATE_RESET[CNT_W-1:0];
    end
    else
    begin
      if (wr_cfg)
      begin
        cfg_r <= cfg_merged;
      end
      if (wr_acr)
      begin
        acr_r <= acr_merged[CNT_W-1:0];
      end
    end
  end

  // Compare buffer and its active shadow
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ccr_buf_r <= tmoc_pkg::COMPARE_RESET[CNT_W-1:0];
      ccr_act_r <= tmoc_pkg::COMPARE_RESET[CNT_W-1:0];
    end
    else
    begin
      if (wr_ccr)
      begin
        ccr_buf_r <= ccr_merged[CNT_W-1:0];
      end
      if (wr_ccr && !preload_en)
      begin
        ccr_act_r <= ccr_merged[CNT_W-1:0]; // see [R04]
      end
      else if (preload_en && timer_events.update)
      begin
        ccr_act_r <= ccr_buf_r; // see [R05]
      end
    end
  end

  // Immediate-active forcing and output reference
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      force_r <= 1'h0;
      ref_r <= tmoc_pkg::REF_RESET;
    end
    else
    begin
      force_r <= force_nxt; // see [R01]
      ref_r <= ref_nxt;
    end
  end

  // Level of the reference for the next cycle
  tmoc_ref_gen #(
    .CNT_W(CNT_W)
  ) u_ref_gen (
    .mode(mode_sel),
    .force_active(force_now),
    .cnt(counter_value),
    .ccr(ccr_act_r),
    .acr(acr_r),
    .down(timer_events.down),
    .ref_now(ref_r),
    .ref_nxt(ref_nxt)
  );

  // Outputs straight from flip-flops
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign output_reference = ref_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_imm_force_set: assert property ( // see [R01]
    timer_events.trigger && imae_en && pwm12 |=> output_reference && force_r)
    else $error("trigger did not force the reference active");

  a_imm_force_end: assert property ( // see [R02]
    force_r && timer_events.wrap && !timer_events.trigger |=> !force_r)
    else $error("forcing outlived the wrap event");

  a_imm_mode_gate: assert property ( // see [R03]
    !pwm12 && !force_r && timer_events.trigger |=> !force_r)
    else $error("forcing acted outside PWM mode 1 or 2");

  a_ccr_direct: assert property ( // see [R04]
    wr_ccr && !preload_en |=> ccr_act_r == ccr_buf_r)
    else $error("compare value not used at once");

  a_ccr_preload_hold: assert property ( // see [R05]
    preload_en && !timer_events.update && !wr_cfg |=> $stable(ccr_act_r))
    else $error("shadow compare moved without update event");

  a_ccr_preload_copy: assert property ( // see [R05]
    preload_en && timer_events.update |=> ccr_act_r == $past(ccr_buf_r))
    else $error("shadow compare not copied on update event");

  a_cfg_mode_read: assert property ( // see [R06]
    ar_take && rd_cfg |=> {rdata_r[8], rdata_r[2:0]} == $past(mode_sel))
    else $error("mode field not read back at bits 8 and 2:0");

  a_match_high: assert property ( // see [R07]
    mode_sel == tmoc_pkg::MODE_MATCH_HIGH && counter_value == ccr_act_r |=> output_reference)
    else $error("reference not high after match");

  a_match_toggle: assert property ( // see [R07]
    mode_sel == tmoc_pkg::MODE_MATCH_TOGGLE && counter_value == ccr_act_r
    |=> output_reference != $past(output_reference))
    else $error("reference did not toggle on match");

  a_force_low: assert property ( // see [R08]
    mode_sel == tmoc_pkg::MODE_FORCE_LOW |=> !output_reference)
    else $error("reference not held inactive");

  a_pwm1_level: assert property ( // see [R09]
    mode_sel == tmoc_pkg::MODE_PWM1 && !force_now && !timer_events.down
    |=> output_reference == $past(counter_value < ccr_act_r))
    else $error("PWM mode 1 up-count level wrong");

  a_pwm2_level: assert property ( // see [R10]
    mode_sel == tmoc_pkg::MODE_PWM2 && !force_now && timer_events.down
    |=> output_reference == $past(counter_value > ccr_act_r))
    else $error("PWM mode 2 down-count level wrong");

  a_asym1_down: assert property ( // see [R11]
    mode_sel == tmoc_pkg::MODE_ASYM1 && timer_events.down
    |=> output_reference == !$past(counter_value > acr_r))
    else $error("asymmetric mode 1 down-count level wrong");

  a_asym2_down: assert property ( // see [R12]
    mode_sel == tmoc_pkg::MODE_ASYM2 && timer_events.down
    |=> output_reference == $past(counter_value > acr_r))
    else $error("asymmetric mode 2 down-count level wrong");

endmodule

// >>> test/tb_tmoc_channel.sv
// Self-checking bench for the compare channel output block.
// Assumes the timer counter and events come from this bench on aclk.
module tb_tmoc_channel;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------
  // Signals and clock
  // ------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic awready;
  logic [11:0] awaddr = 12'h000;
  logic wvalid = 1'b0;
  logic wready;
  logic [31:0] wdata = 32'h0;
  logic bvalid;
  logic bready = 1'b0;
  logic [1:0] bresp;
  logic arvalid = 1'b0;
  logic arready;
  logic [11:0] araddr = 12'h000;
  logic rvalid;
  logic rready = 1'b0;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [15:0] counter_value = 16'h0;
  tmoc_pkg::tmoc_timer_s timer_events = '0;
  logic output_reference;
  int fails = 0;
  int compares = 0;

  typedef struct {
    tmoc_pkg::tmoc_mode_e m;
    logic [15:0] c;
    logic dn;
    logic e;
  } tmoc_row_s;

  // Compare 100, alternate 40; counter, direction and expected level
  // Asymmetric rows count both ways, as centre-aligned counting does
  tmoc_row_s rows [16] = '{
    '{tmoc_pkg::MODE_PWM1, 16'h63, 1'b0, 1'b1}, '{tmoc_pkg::MODE_PWM1, 16'h64, 1'b0, 1'b0},
    '{tmoc_pkg::MODE_PWM1, 16'h65, 1'b1, 1'b0}, '{tmoc_pkg::MODE_PWM1, 16'h64, 1'b1, 1'b1},
    '{tmoc_pkg::MODE_PWM2, 16'h63, 1'b0, 1'b0}, '{tmoc_pkg::MODE_PWM2, 16'h64, 1'b0, 1'b1},
    '{tmoc_pkg::MODE_PWM2, 16'h65, 1'b1, 1'b1}, '{tmoc_pkg::MODE_PWM2, 16'h64, 1'b1, 1'b0},
    '{tmoc_pkg::MODE_ASYM1, 16'h63, 1'b0, 1'b1}, '{tmoc_pkg::MODE_ASYM1, 16'h32, 1'b1, 1'b0},
    '{tmoc_pkg::MODE_ASYM1, 16'h28, 1'b1, 1'b1}, '{tmoc_pkg::MODE_ASYM2, 16'h63, 1'b0, 1'b0},
    '{tmoc_pkg::MODE_ASYM2, 16'h32, 1'b1, 1'b1}, '{tmoc_pkg::MODE_ASYM2, 16'h28, 1'b1, 1'b0},
    '{tmoc_pkg::MODE_FORCE_HIGH, 16'h32, 1'b0, 1'b1},
    '{tmoc_pkg::MODE_FORCE_LOW, 16'h32, 1'b0, 1'b0}};

  // Free running clock, 50 ns period
  always #25 aclk = ~aclk;

  tmoc_channel #(
    .CNT_W(16)
  ) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .counter_value(counter_value), .timer_events(timer_events),
    .output_reference(output_reference)
  );

  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Bus wait ran out
  task automatic give_up();
    fails++;
    $display("timeout waiting for bus answer");
    summarize();
  endtask

  // Config word: mode bit 3 at 8, bits 2:0 at 2:0
  function automatic logic [31:0] cfg(tmoc_pkg::tmoc_mode_e m, logic ie, logic pre);
    return {23'h0, m[3], 2'h0, ie, pre, 1'h0, m[2:0]};
  endfunction

  // Write cycle; address and data offered together
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 40)
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, er});
        n = 100;
      end
    end
    if (n != 100)
      give_up();
  endtask

  // Read cycle with expected data and response
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 40)
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        rready <= 1'b0;
        check("rdata", rdata, ed);
        check("rresp", {30'h0, rresp}, {30'h0, er});
        n = 100;
      end
    end
    if (n != 100)
      give_up();
  endtask

  // Counter c with pulses p = {update, wrap, trigger} for one cycle, then c2
  task automatic apply(input logic [15:0] c, input logic [15:0] c2, input logic dn,
                       input logic [2:0] p);
    @(posedge aclk);
    counter_value <= c;
    timer_events <= {dn, p};
    @(posedge aclk);
    counter_value <= c2;
    timer_events <= {dn, 3'h0};
  endtask

  // Reference level after the sampled cycle
  task automatic ref_is(input logic e);
    @(posedge aclk);
    check("output_reference", {31'h0, output_reference}, {31'h0, e});
  endtask

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    ref_is(1'b0);
    axi_rd(tmoc_pkg::OFF_CONFIG, tmoc_pkg::CONFIG_RESET, tmoc_pkg::RESP_OKAY);
    axi_rd(tmoc_pkg::OFF_COMPARE, tmoc_pkg::COMPARE_RESET, tmoc_pkg::RESP_OKAY);
    axi_rd(tmoc_pkg::OFF_ALTERNATE, tmoc_pkg::ALTERNATE_RESET, tmoc_pkg::RESP_OKAY);
    axi_rd(12'h04c, 32'h0, tmoc_pkg::RESP_SLVERR);
    axi_wr(12'h04c, 32'hffffffff, tmoc_pkg::RESP_SLVERR);
    axi_wr(tmoc_pkg::OFF_CONFIG, 32'hffffffff, tmoc_pkg::RESP_OKAY);
    axi_rd(tmoc_pkg::OFF_CONFIG, 32'h00000137, tmoc_pkg::RESP_OKAY);
    $display("test registers done");
    // Preload off again, so the compare reaches the shadow at once
    axi_wr(tmoc_pkg::OFF_CONFIG, tmoc_pkg::CONFIG_RESET, tmoc_pkg::RESP_OKAY);
    axi_wr(tmoc_pkg::OFF_COMPARE, 32'h64, tmoc_pkg::RESP_OKAY);
    axi_wr(tmoc_pkg::OFF_ALTERNATE, 32'h28, tmoc_pkg::RESP_OKAY);
    // Level modes from the table
    for (int i = 0; i < 16; i++)
    begin
      axi_wr(tmoc_pkg::OFF_CONFIG, cfg(rows[i].m, 1'b0, 1'b0), tmoc_pkg::RESP_OKAY);
      apply(rows[i].c, rows[i].c, rows[i].dn, 3'h0);
      ref_is(rows[i].e);
    end
    $display("test level modes done");
    // Match modes, one matching cycle each, two for toggle, several for hold
    axi_wr(tmoc_pkg::OFF_CONFIG, cfg(tmoc_pkg::MODE_MATCH_HIGH, 1'b0, 1'b0), 2'h0);
    apply(16'h64, 16'h7, 1'b0, 3'h0);
    ref_is(1'b1);
    axi_wr(tmoc_pkg::OFF_CONFIG, cfg(tmoc_pkg::MODE_HOLD, 1'b0, 1'b0), 2'h0);
    axi_wr(tmoc_pkg::OFF_COMPARE, 32'h7, tmoc_pkg::RESP_OKAY);
    apply(16'h7, 16'h7, 1'b1, 3'h0);
    ref_is(1'b1);
    axi_wr(tmoc_pkg::OFF_COMPARE, 32'h64, tmoc_pkg::RESP_OKAY);
    axi_wr(tmoc_pkg::OFF_CONFIG, cfg(tmoc_pkg::MODE_MATCH_LOW, 1'b0, 1'b0), 2'h0);
    apply(16'h64, 16'h7, 1'b0, 3'h0);
    ref_is(1'b0);
    axi_wr(tmoc_pkg::OFF_CONFIG, cfg(tmoc_pkg::MODE_MATCH_TOGGLE, 1'b0, 1'b0), 2'h0);
    apply(16'h64, 16'h7, 1'b0, 3'h0);
    ref_is(1'b1);
    apply(16'h64, 16'h7, 1'b0, 3'h0);
    ref_is(1'b0);
    $display("test match modes done");
    // Compare preload off, then on
    axi_wr(tmoc_pkg::OFF_CONFIG, cfg(tmoc_pkg::MODE_PWM1, 1'b0, 1'b0), 2'h0);
    axi_wr(tmoc_pkg::OFF_COMPARE, 32'h1e, tmoc_pkg::RESP_OKAY);
    apply(16'h32, 16'h32, 1'b0, 3'h0);
    ref_is(1'b0);
    axi_wr(tmoc_pkg::OFF_CONFIG, cfg(tmoc_pkg::MODE_PWM1, 1'b0, 1'b1), 2'h0);
    axi_wr(tmoc_pkg::OFF_COMPARE, 32'h50, tmoc_pkg::RESP_OKAY);
    apply(16'h32, 16'h32, 1'b0, 3'h0);
    ref_is(1'b0);
    // Shadow is loaded at the update edge and compared from the next one
    apply(16'h32, 16'h32, 1'b0, 3'h4);
    @(posedge aclk);
    ref_is(1'b1);
    axi_rd(tmoc_pkg::OFF_COMPARE, 32'h50, tmoc_pkg::RESP_OKAY);
    $display("test preload done");
    // Immediate active: trigger, hold, wrap; ignored outside PWM modes
    axi_wr(tmoc_pkg::OFF_CONFIG, cfg(tmoc_pkg::MODE_PWM1, 1'b1, 1'b0), 2'h0);
    apply(16'h5a, 16'h5a, 1'b0, 3'h0);
    ref_is(1'b0);
    apply(16'h5a, 16'h5a, 1'b0, 3'h1);
    ref_is(1'b1);
    axi_rd(tmoc_pkg::OFF_STATUS, 32'h3, tmoc_pkg::RESP_OKAY);
    ref_is(1'b1);
    // Forcing still covers the wrap cycle and drops after it
    apply(16'h5a, 16'h5a, 1'b0, 3'h2);
    ref_is(1'b1);
    ref_is(1'b0);
    axi_wr(tmoc_pkg::OFF_CONFIG, cfg(tmoc_pkg::MODE_PWM2, 1'b1, 1'b0), 2'h0);
    apply(16'h32, 16'h32, 1'b0, 3'h1);
    ref_is(1'b1);
    // Trigger together with wrap keeps the forcing alive
    apply(16'h32, 16'h32, 1'b0, 3'h3);
    ref_is(1'b1);
    apply(16'h32, 16'h32, 1'b0, 3'h2);
    ref_is(1'b1);
    ref_is(1'b0);
    axi_wr(tmoc_pkg::OFF_CONFIG, cfg(tmoc_pkg::MODE_FORCE_LOW, 1'b1, 1'b0), 2'h0);
    apply(16'h32, 16'h32, 1'b0, 3'h1);
    ref_is(1'b0);
    axi_wr(tmoc_pkg::OFF_STATUS, 32'h3, tmoc_pkg::RESP_OKAY);
    $display("test immediate active done");
    // Reset in mid-run clears reference and config
    axi_wr(tmoc_pkg::OFF_CONFIG, cfg(tmoc_pkg::MODE_FORCE_HIGH, 1'b0, 1'b0), 2'h0);
    ref_is(1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    ref_is(1'b0);
    axi_rd(tmoc_pkg::OFF_CONFIG, tmoc_pkg::CONFIG_RESET, tmoc_pkg::RESP_OKAY);
    $display("test second reset done");
    summarize();
  end
endmodule
